// [rtl/btcce_defs.svh]
// Constants for the bit-test, call, clear and watchdog-clear execution block.
`ifndef BTCCE_DEFS_SVH
`define BTCCE_DEFS_SVH
`define BTCCE_ZERO_BYTE 8'h00
`define BTCCE_FADDR_MAX 5'h1f
`define BTCCE_DEST_W 1'b0
`define BTCCE_DEST_F 1'b1
`define BTCCE_STAT_PAGE_HI 6
`define BTCCE_STAT_PAGE_LO 5
`define BTCCE_PC_W 11
`define BTCCE_PC_ONE 11'h001
`define BTCCE_CALL_CYCLES 2'h2
`define BTCCE_SKIP_CYCLES 2'h2
`define BTCCE_ONE_CYCLE 2'h1
`endif

// [rtl/btcce_pkg.sv]
// Types shared by the bit-test, call, clear and watchdog-clear execution block.
package btcce_pkg;

    typedef enum logic [2:0] {
        BTCCE_OP_NONE,
        BTCCE_OP_AND_WORKING_WITH_FILE,
        BTCCE_OP_SKIP_IF_BIT_CLEAR,
        BTCCE_OP_SKIP_IF_BIT_SET,
        BTCCE_OP_CLEAR_WORKING_REG,
        BTCCE_OP_CLEAR_FILE_REG,
        BTCCE_OP_CALL,
        BTCCE_OP_CLEAR_WATCHDOG_INSTR
    } btcce_op_e;

    typedef struct packed {
        logic valid;
        btcce_op_e op;
        logic [4:0] faddr;
        logic dest;
        logic [2:0] bitsel;
        logic [7:0] literal;
    } btcce_instr_s;

    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } btcce_fwr_s;

    typedef enum logic {
        BTCCE_ST_EXEC,
        BTCCE_ST_SECOND
    } btcce_state_e;

endpackage : btcce_pkg

// [rtl/btcce_exec.sv]
// Execution stage for bit tests, subroutine call, clears and watchdog clear.
`timescale 1ns/1ps
`default_nettype none
`include "btcce_defs.svh"

// Operation
// - AND working register with file register 0..31; only zero flag updated.
// - Destination select 0 writes working register, 1 writes file register.
// - Skip-if-bit-clear tests bit 0..7, skips when zero, flags unchanged.
// - Taken skip discards fetched instruction, runs idle cycle; two cycles total.
// - Skip-if-bit-set tests selected bit, skips when one, flags unchanged.
// - Clear working register loads 00h and sets zero flag.
// - Call pushes program counter plus one onto the stack first.
// - Call loads literal into counter bits 7:0, status 6:5 into bits 10:9.
// - Call clears counter bit 8, takes two cycles, leaves flags unchanged.
// - Watchdog clear zeroes counter, and prescaler only when assigned to watchdog.
// - Watchdog clear sets expiry and sleep status bits to one.
// - Clear file register writes 00h and sets zero flag.
module btcce_exec
    import btcce_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire btcce_instr_s instr_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] working_i,
    input wire logic [7:0] status_i,
    input wire logic [`BTCCE_PC_W-1:0] program_counter_i,
    input wire logic prescaler_to_watchdog_i,
    output logic [4:0] file_raddr_o,
    output btcce_fwr_s file_wr_o,
    output logic working_we_o,
    output logic [7:0] working_wdata_o,
    output logic zero_we_o,
    output logic zero_o,
    output logic stack_push_o,
    output logic [`BTCCE_PC_W-1:0] stack_wdata_o,
    output logic pc_load_o,
    output logic [`BTCCE_PC_W-1:0] program_counter_o,
    output logic watchdog_counter_clr_o,
    output logic prescaler_clr_o,
    output logic status_bits_set_o,
    output logic idle_cycle_o,
    output logic busy_o
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic bit_of(input logic [7:0] v, input logic [2:0] b);
        bit_of = v[b];
    endfunction : bit_of

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == `BTCCE_ZERO_BYTE);
    endfunction : is_zero

    // ==========================================================
    // Execution state and output registers
    // ==========================================================
    btcce_state_e state_r, state_nxt;
    btcce_fwr_s file_wr_r, file_wr_nxt;
    logic working_we_r, working_we_nxt;
    logic [7:0] working_wdata_r, working_wdata_nxt;
    logic zero_we_r, zero_we_nxt;
    logic zero_r, zero_nxt;
    logic stack_push_r, stack_push_nxt;
    logic [`BTCCE_PC_W-1:0] stack_wdata_r, stack_wdata_nxt;
    logic pc_load_r, pc_load_nxt;
    logic [`BTCCE_PC_W-1:0] pc_r, pc_nxt;
    logic wdt_clr_r, wdt_clr_nxt;
    logic pre_clr_r, pre_clr_nxt;
    logic stat_set_r, stat_set_nxt;
    logic idle_r, idle_nxt;
    logic [7:0] and_res;
    logic accept;

    assign file_raddr_o = instr_i.faddr;
    assign and_res = working_i & file_rdata_i;
    assign accept = instr_i.valid && (state_r == BTCCE_ST_EXEC);

    always_comb
    begin
        state_nxt = BTCCE_ST_EXEC;
        file_wr_nxt = '0;
        working_we_nxt = 1'b0;
        working_wdata_nxt = working_wdata_r;
        zero_we_nxt = 1'b0;
        zero_nxt = zero_r;
        stack_push_nxt = 1'b0;
        stack_wdata_nxt = stack_wdata_r;
        pc_load_nxt = 1'b0;
        pc_nxt = pc_r;
        wdt_clr_nxt = 1'b0;
        pre_clr_nxt = 1'b0;
        stat_set_nxt = 1'b0;
        idle_nxt = 1'b0;
        if (state_r == BTCCE_ST_SECOND)
        begin
            // Second cycle: fetched instruction is dropped as an idle cycle.
            idle_nxt = 1'b1;
        end
        else if (accept)
        begin
            unique case (instr_i.op)
                BTCCE_OP_AND_WORKING_WITH_FILE:
                begin
                    zero_we_nxt = 1'b1;
                    zero_nxt = is_zero(and_res);
                    if (instr_i.dest == `BTCCE_DEST_W)
                    begin
                        working_we_nxt = 1'b1;
                        working_wdata_nxt = and_res;
                    end
                    else
                    begin
                        file_wr_nxt.we = 1'b1;
                        file_wr_nxt.addr = instr_i.faddr;
                        file_wr_nxt.data = and_res;
                    end
                end
                BTCCE_OP_SKIP_IF_BIT_CLEAR:
                begin
                    if (!bit_of(file_rdata_i, instr_i.bitsel))
                    begin
                        state_nxt = BTCCE_ST_SECOND;
                    end
                end
                BTCCE_OP_SKIP_IF_BIT_SET:
                begin
                    if (bit_of(file_rdata_i, instr_i.bitsel))
                    begin
                        state_nxt = BTCCE_ST_SECOND;
                    end
                end
                BTCCE_OP_CLEAR_WORKING_REG:
                begin
                    working_we_nxt = 1'b1;
                    working_wdata_nxt = `BTCCE_ZERO_BYTE;
                    zero_we_nxt = 1'b1;
                    zero_nxt = 1'b1;
                end
                BTCCE_OP_CLEAR_FILE_REG:
                begin
                    file_wr_nxt.we = 1'b1;
                    file_wr_nxt.addr = instr_i.faddr;
                    file_wr_nxt.data = `BTCCE_ZERO_BYTE;
                    zero_we_nxt = 1'b1;
                    zero_nxt = 1'b1;
                end
                BTCCE_OP_CALL:
                begin
                    stack_push_nxt = 1'b1;
                    stack_wdata_nxt = program_counter_i + `BTCCE_PC_ONE;
                    pc_load_nxt = 1'b1;
                    pc_nxt = {status_i[`BTCCE_STAT_PAGE_HI:`BTCCE_STAT_PAGE_LO], 1'b0,
                              instr_i.literal};
                    state_nxt = BTCCE_ST_SECOND;
                end
                BTCCE_OP_CLEAR_WATCHDOG_INSTR:
                begin
                    wdt_clr_nxt = 1'b1;
                    pre_clr_nxt = prescaler_to_watchdog_i;
                    stat_set_nxt = 1'b1;
                end
                default:
                begin
                    state_nxt = BTCCE_ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= BTCCE_ST_EXEC;
            file_wr_r <= '0;
            working_we_r <= 1'b0;
            working_wdata_r <= `BTCCE_ZERO_BYTE;
            zero_we_r <= 1'b0;
            zero_r <= 1'b0;
            stack_push_r <= 1'b0;
            stack_wdata_r <= '0;
            pc_load_r <= 1'b0;
            pc_r <= '0;
            wdt_clr_r <= 1'b0;
            pre_clr_r <= 1'b0;
            stat_set_r <= 1'b0;
            idle_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            file_wr_r <= file_wr_nxt;
            working_we_r <= working_we_nxt;
            working_wdata_r <= working_wdata_nxt;
            zero_we_r <= zero_we_nxt;
            zero_r <= zero_nxt;
            stack_push_r <= stack_push_nxt;
            stack_wdata_r <= stack_wdata_nxt;
            pc_load_r <= pc_load_nxt;
            pc_r <= pc_nxt;
            wdt_clr_r <= wdt_clr_nxt;
            pre_clr_r <= pre_clr_nxt;
            stat_set_r <= stat_set_nxt;
            idle_r <= idle_nxt;
        end
    end

    assign file_wr_o = file_wr_r;
    assign working_we_o = working_we_r;
    assign working_wdata_o = working_wdata_r;
    assign zero_we_o = zero_we_r;
    assign zero_o = zero_r;
    assign stack_push_o = stack_push_r;
    assign stack_wdata_o = stack_wdata_r;
    assign pc_load_o = pc_load_r;
    assign program_counter_o = pc_r;
    assign watchdog_counter_clr_o = wdt_clr_r;
    assign prescaler_clr_o = pre_clr_r;
    assign status_bits_set_o = stat_set_r;
    assign idle_cycle_o = idle_r;
    assign busy_o = (state_r == BTCCE_ST_SECOND);

    // ==========================================================
    // Checks
    // ==========================================================
    property p_and_zero;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_AND_WORKING_WITH_FILE
        |=> zero_we_o && zero_o == ($past(working_i & file_rdata_i) == 8'h00);
    endproperty
    a_and_zero: assert property (p_and_zero) else $error("AND zero flag wrong.");

    property p_and_dest;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_AND_WORKING_WITH_FILE
        |=> (working_we_o != file_wr_o.we) && (working_we_o == !$past(instr_i.dest));
    endproperty
    a_and_dest: assert property (p_and_dest) else $error("AND destination wrong.");

    property p_skip_clr;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_SKIP_IF_BIT_CLEAR && !file_rdata_i[instr_i.bitsel]
        |=> busy_o && !zero_we_o ##1 idle_cycle_o && !busy_o;
    endproperty
    a_skip_clr: assert property (p_skip_clr) else $error("Skip on clear failed.");

    property p_skip_two;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        idle_cycle_o |-> $past(busy_o) && !file_wr_o.we && !working_we_o;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("Idle cycle wrong.");

    property p_skip_set;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_SKIP_IF_BIT_SET
        |=> busy_o == $past(file_rdata_i[instr_i.bitsel]) && !zero_we_o;
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("Skip on set failed.");

    property p_clear_working_reg;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_CLEAR_WORKING_REG
        |=> working_we_o && working_wdata_o == 8'h00 && zero_o && zero_we_o;
    endproperty
    a_clear_working_reg: assert property (p_clear_working_reg) else $error("Clear working failed.");

    property p_call;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_CALL
        |=> stack_push_o && stack_wdata_o == $past(program_counter_i) + 11'h001
            && program_counter_o[7:0] == $past(instr_i.literal)
            && program_counter_o[10:9] == $past(status_i[6:5])
            && !program_counter_o[8] && !zero_we_o ##1 idle_cycle_o;
    endproperty
    a_call: assert property (p_call) else $error("Call failed.");

    property p_clear_watchdog_instr;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_CLEAR_WATCHDOG_INSTR
        |=> watchdog_counter_clr_o && status_bits_set_o
            && prescaler_clr_o == $past(prescaler_to_watchdog_i);
    endproperty
    a_clear_watchdog_instr: assert property (p_clear_watchdog_instr) else $error("Watchdog clear failed.");

    property p_clear_file_reg;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_CLEAR_FILE_REG
        |=> file_wr_o.we && file_wr_o.data == 8'h00 && file_wr_o.addr == $past(instr_i.faddr)
            && zero_o && !busy_o;
    endproperty
    a_clear_file_reg: assert property (p_clear_file_reg) else $error("Clear file failed.");

    property p_call_two;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && instr_i.op == BTCCE_OP_CALL
        |=> busy_o && pc_load_o && !zero_we_o && !status_bits_set_o
            ##1 !busy_o && !pc_load_o && !stack_push_o;
    endproperty
    a_call_two: assert property (p_call_two) else $error("Call length wrong.");

    property p_status_set;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        status_bits_set_o |-> $past(accept) && $past(instr_i.op) == BTCCE_OP_CLEAR_WATCHDOG_INSTR;
    endproperty
    a_status_set: assert property (p_status_set) else $error("Status set wrong.");

    property p_one_cycle;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        accept && (instr_i.op == BTCCE_OP_AND_WORKING_WITH_FILE
            || instr_i.op == BTCCE_OP_CLEAR_WORKING_REG
            || instr_i.op == BTCCE_OP_CLEAR_FILE_REG
            || instr_i.op == BTCCE_OP_CLEAR_WATCHDOG_INSTR)
        |=> !busy_o && !idle_cycle_o;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("Op stalled.");

endmodule : btcce_exec
`default_nettype wire

// [dv/bit_test_call_clear_exec_tb_top.sv]
// Self-checking testbench for the bit-test, call and clear execution block.
`timescale 1ns/1ps
`default_nettype none
module bit_test_call_clear_exec_tb_top import btcce_pkg::*;;
    // ==========================================================
    // Signals and scoreboard.
    typedef struct packed {
        logic fwe;
        logic [4:0] fa;
        logic [7:0] fd;
        logic wwe;
        logic [7:0] wd;
        logic zwe, z, push;
        logic [10:0] sd;
        logic load;
        logic [10:0] pc;
        logic wdc, pcl, sts, idle, busy;
    } btcce_tb_obs_s;
    logic clk_sys_i, sys_rst_i, prescaler_to_watchdog_i, ps;
    btcce_instr_s instr_i, ins;
    logic [7:0] file_rdata_i, working_i, status_i, w, st;
    logic [10:0] program_counter_i, pc;
    logic [4:0] file_raddr_o;
    btcce_fwr_s file_wr_o;
    logic working_we_o, zero_we_o, zero_o, stack_push_o, pc_load_o;
    logic [7:0] working_wdata_o;
    logic [10:0] stack_wdata_o, program_counter_o;
    logic watchdog_counter_clr_o, prescaler_clr_o, status_bits_set_o, idle_cycle_o, busy_o;
    logic [7:0] fmem [32];
    logic [31:0] seed = 32'h8583;
    btcce_tb_obs_s e, o, x, q[$];
    int miscompares, comparisons;
    assign file_rdata_i = fmem[file_raddr_o];
    btcce_exec dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
        .file_rdata_i(file_rdata_i), .working_i(working_i), .status_i(status_i),
        .program_counter_i(program_counter_i), .prescaler_to_watchdog_i(prescaler_to_watchdog_i),
        .file_raddr_o(file_raddr_o), .file_wr_o(file_wr_o), .working_we_o(working_we_o),
        .working_wdata_o(working_wdata_o), .zero_we_o(zero_we_o), .zero_o(zero_o),
        .stack_push_o(stack_push_o), .stack_wdata_o(stack_wdata_o), .pc_load_o(pc_load_o),
        .program_counter_o(program_counter_o), .watchdog_counter_clr_o(watchdog_counter_clr_o),
        .prescaler_clr_o(prescaler_clr_o), .status_bits_set_o(status_bits_set_o),
        .idle_cycle_o(idle_cycle_o), .busy_o(busy_o));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // Helpers.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input btcce_tb_obs_s ex, input btcce_tb_obs_s got);
        comparisons++;
        if (got !== ex)
        begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic setup(input btcce_op_e op);
        ins = 21'(rnd() >> 11);
        ins.valid = 1'b1;
        ins.op = op;
        void'(rnd());
        w = seed[7:0];
        st = seed[15:8];
        pc = seed[26:16];
        ps = seed[31];
        e = '0;
    endtask : setup
    task automatic go(input logic two);
        @(posedge clk_sys_i);
        instr_i <= ins;
        working_i <= w;
        status_i <= st;
        program_counter_i <= pc;
        prescaler_to_watchdog_i <= ps;
        if (two)
        begin
            ins.op = BTCCE_OP_CLEAR_FILE_REG;
            @(posedge clk_sys_i);
            instr_i <= ins;
        end
    endtask : go
    task automatic drain(input string name);
        @(posedge clk_sys_i);
        instr_i <= '0;
        for (int k = 0; k < 20 && q.size() != 0; k++)
            @(negedge clk_sys_i);
        if (q.size() != 0)
        begin
            miscompares++;
            conclude();
        end
        else
            $display("test %s done", name);
    endtask : drain
    // ==========================================================
    // Output monitor.
    always @(negedge clk_sys_i)
    begin
        if (sys_rst_i === 1'b0)
        begin
            o = '0;
            o.fwe = file_wr_o.we;
            o.fa = (o.fwe !== 1'b0) ? file_wr_o.addr : 5'h00;
            o.fd = (o.fwe !== 1'b0) ? file_wr_o.data : 8'h00;
            o.wwe = working_we_o;
            o.wd = (o.wwe !== 1'b0) ? working_wdata_o : 8'h00;
            o.zwe = zero_we_o;
            o.z = (o.zwe !== 1'b0) ? zero_o : 1'b0;
            o.push = stack_push_o;
            o.sd = (o.push !== 1'b0) ? stack_wdata_o : 11'h000;
            o.load = pc_load_o;
            o.pc = (o.load !== 1'b0) ? program_counter_o : 11'h000;
            o.wdc = watchdog_counter_clr_o;
            o.pcl = prescaler_clr_o;
            o.sts = status_bits_set_o;
            o.idle = idle_cycle_o;
            o.busy = busy_o;
            if (o !== '0)
            begin
                x = '0;
                if (q.size() != 0)
                    x = q.pop_front();
                chk(x, o);
            end
        end
    end
    // ==========================================================
    // Stimulus.
    initial
    begin
        for (int k = 0; k < 32; k++)
            fmem[k] = 8'(rnd() >> 24);
        fmem[0] = 8'h00;
        fmem[31] = 8'hff;
        instr_i = '0;
        working_i = 8'h00;
        status_i = 8'h00;
        program_counter_i = 11'h000;
        prescaler_to_watchdog_i = 1'b0;
        sys_rst_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            setup(BTCCE_OP_AND_WORKING_WITH_FILE);
            if (i < 2)
                ins.faddr = {5{i[0]}};
            ins.dest = i[0];
            e.zwe = 1'b1;
            e.z = ((w & fmem[ins.faddr]) == 8'h00);
            e.fwe = ins.dest;
            e.fa = ins.dest ? ins.faddr : 5'h00;
            e.fd = ins.dest ? (w & fmem[ins.faddr]) : 8'h00;
            e.wwe = !ins.dest;
            e.wd = ins.dest ? 8'h00 : (w & fmem[ins.faddr]);
            q.push_back(e);
            go(1'b0);
        end
        drain("and");
        for (int i = 0; i < 32; i++)
        begin
            setup(btcce_op_e'(i[4] ? BTCCE_OP_SKIP_IF_BIT_SET : BTCCE_OP_SKIP_IF_BIT_CLEAR));
            ins.faddr = {5{i[3]}};
            ins.bitsel = i[2:0];
            if (i[3] == i[4])
            begin
                e.busy = 1'b1;
                q.push_back(e);
                e = '0;
                e.idle = 1'b1;
                q.push_back(e);
            end
            go(i[3] == i[4]);
        end
        drain("skip");
        for (int i = 0; i < 4; i++)
        begin
            setup(btcce_op_e'(i[0] ? BTCCE_OP_CLEAR_FILE_REG : BTCCE_OP_CLEAR_WORKING_REG));
            e.zwe = 1'b1;
            e.z = 1'b1;
            e.fwe = i[0];
            e.fa = i[0] ? ins.faddr : 5'h00;
            e.wwe = !i[0];
            q.push_back(e);
            go(1'b0);
        end
        setup(BTCCE_OP_NONE);
        go(1'b0);
        setup(BTCCE_OP_CLEAR_FILE_REG);
        ins.valid = 1'b0;
        go(1'b0);
        drain("clear");
        for (int i = 0; i < 4; i++)
        begin
            setup(BTCCE_OP_CALL);
            if (i == 0)
                {ins.literal, pc} = {8'hff, 11'h7ff};
            {e.push, e.load, e.busy} = 3'h7;
            e.sd = pc + 11'h001;
            e.pc = {st[6:5], 1'b0, ins.literal};
            q.push_back(e);
            e = '0;
            e.idle = 1'b1;
            q.push_back(e);
            go(1'b1);
        end
        drain("call");
        for (int i = 0; i < 2; i++)
        begin
            setup(BTCCE_OP_CLEAR_WATCHDOG_INSTR);
            ps = i[0];
            {e.wdc, e.pcl, e.sts} = {1'b1, ps, 1'b1};
            q.push_back(e);
            go(1'b0);
        end
        drain("watchdog");
        conclude();
    end
endmodule : bit_test_call_clear_exec_tb_top
`default_nettype wire
